/* interrupt_status_flag_bank_test.sv */
`timescale 1ns/1ps
module interrupt_status_flag_bank_test;
   import isfb_pkg::*;
   logic core_clk, rst_b, wr, rd, ext3_pin, ext0_enable, uart_enable;
   logic [7:0] addr, wdata, rdata, irq_mask_one, irq_mask_two;
   logic [14:0] evt_v;
   isfb_flags_t flags;
   int err_count, samples_checked, cyc;
   int ev1[7] = '{12, 11, 10, 9, 8, 7, 6};
   int fb1[7] = '{7, 6, 5, 3, 2, 1, 0};
   int ev2[6] = '{5, 4, 3, 2, 1, 0};
   int fb2[6] = '{6, 5, 4, 3, 2, 0};

   isfb_flag_bank i_dut (.core_clk(core_clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .evt(isfb_events_t'(evt_v)), .ext3_pin(ext3_pin),
      .ext0_enable(ext0_enable), .uart_enable(uart_enable), .flags(flags),
      .irq_mask_one(irq_mask_one), .irq_mask_two(irq_mask_two));
   isfb_cpu_model i_cpu (.core_clk(core_clk), .rdata(rdata), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
         err_count++;
      end
   endtask : chk

   task automatic pulse(input int idx);
      @(posedge core_clk);
      evt_v <= 15'h0001 << idx;
      @(posedge core_clk);
      evt_v <= 15'h0000;
      #1;
   endtask : pulse

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_reset;
      logic [7:0] d;
      chk(flags.zero_edge | flags.one | flags.two, 8'h00, "flags after reset");
      chk(irq_mask_one | irq_mask_two, 8'h00, "masks after reset");
      for (int a = 13; a < 18; a++) begin
         i_cpu.bus_read(8'(a), d);
         chk(d, 8'h00, "read after reset");
      end
      $display("reset test done");
   endtask : test_reset

   task automatic test_flags_one;
      logic [7:0] d, exp;
      exp = 8'h00;
      for (int i = 0; i < 7; i++) begin
         pulse(ev1[i]);
         exp[fb1[i]] = 1'b1;
         chk(flags.one, exp, "flag one set");
      end
      i_cpu.bus_write(ISFB_ADDR_MASK_ONE, 8'h0F);
      i_cpu.bus_read(ISFB_ADDR_FLAGS_ONE, d);
      chk(d, 8'h0F, "masked read one");
      i_cpu.bus_write(ISFB_ADDR_MASK_ONE, 8'hFF);
      i_cpu.bus_read(ISFB_ADDR_FLAGS_ONE, d);
      chk(d, 8'hEF, "full read one");
      i_cpu.bus_write(ISFB_ADDR_FLAGS_ONE, 8'hFB);
      #1 chk(flags.one, 8'hEB, "write clears bit 2");
      i_cpu.bus_write(ISFB_ADDR_FLAGS_ONE, 8'h00);
      i_cpu.bus_write(ISFB_ADDR_FLAGS_ONE, 8'hFF);
      #1 chk(flags.one, 8'h00, "write never sets one");
      $display("flag one test done");
   endtask : test_flags_one

   task automatic test_flags_two;
      logic [7:0] d, exp;
      exp = 8'h00;
      for (int i = 0; i < 6; i++) begin
         pulse(ev2[i]);
         exp[fb2[i]] = 1'b1;
         chk(flags.two, exp, "flag two set");
      end
      i_cpu.bus_write(ISFB_ADDR_MASK_TWO, 8'h30);
      i_cpu.bus_read(ISFB_ADDR_FLAGS_TWO, d);
      chk(d, 8'h30, "masked read two");
      i_cpu.bus_write(ISFB_ADDR_FLAGS_TWO, 8'hFE);
      #1 chk(flags.two, 8'h7C, "write clears bit 0");
      @(posedge core_clk);
      uart_enable <= 1'b0;
      @(posedge core_clk);
      #1 chk(flags.two, 8'h3C, "uart off clears error");
      pulse(5);
      chk(flags.two, 8'h3C, "error blocked while off");
      @(posedge core_clk);
      uart_enable <= 1'b1;
      i_cpu.bus_write(ISFB_ADDR_FLAGS_TWO, 8'h00);
      i_cpu.bus_write(ISFB_ADDR_FLAGS_TWO, 8'hFF);
      #1 chk(flags.two, 8'h00, "write never sets two");
      $display("flag two test done");
   endtask : test_flags_two

   task automatic test_flags_zero;
      logic [7:0] d;
      pulse(14);
      pulse(13);
      i_cpu.bus_read(ISFB_ADDR_FLAGS_ZERO, d);
      chk(d, 8'h03, "raw read zero");
      @(posedge core_clk);
      ext0_enable <= 1'b0;
      @(posedge core_clk);
      #1 chk(flags.zero_edge, 8'h02, "ext0 off clears");
      pulse(13);
      chk(flags.zero_edge, 8'h02, "ext0 blocked while off");
      @(posedge core_clk);
      ext0_enable <= 1'b1;
      i_cpu.bus_write(ISFB_ADDR_FLAGS_ZERO, 8'h00);
      @(posedge core_clk);
      ext3_pin <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1 chk(flags.zero_edge, 8'h10, "rising edge seen");
      @(posedge core_clk);
      ext3_pin <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1 chk(flags.zero_edge, 8'h30, "falling edge seen");
      i_cpu.bus_write(ISFB_ADDR_FLAGS_ZERO, 8'hEF);
      #1 chk(flags.zero_edge, 8'h20, "clear rise only");
      $display("flag zero test done");
   endtask : test_flags_zero

   task automatic test_misc;
      logic [7:0] d;
      fork
         i_cpu.bus_write(ISFB_ADDR_FLAGS_ONE, 8'h00);
         pulse(10);
      join
      chk(flags.one, 8'h20, "set beats clear");
      i_cpu.bus_write(8'h12, 8'hFF);
      i_cpu.bus_read(8'h12, d);
      chk(d, 8'h00, "unmapped read");
      chk(irq_mask_one & irq_mask_two, 8'h30, "masks kept");
      chk(irq_mask_one, 8'hFF, "mask one kept");
      i_cpu.bus_read(ISFB_ADDR_MASK_TWO, d);
      chk(d, 8'h30, "mask two readback");
      i_cpu.bus_read(ISFB_ADDR_FLAGS_ONE, d);
      chk(d, 8'h20, "masked read after set");
      @(posedge core_clk);
      #1 chk(rdata, 8'h00, "read data one cycle");
      $display("misc test done");
   endtask : test_misc

   // ----------------------------------------------------------------
   // clock, reset, sequence
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         end_sim();
      end
   end

   initial begin
      rst_b = 1'b0;
      evt_v = 15'h0000;
      ext3_pin = 1'b0;
      ext0_enable = 1'b1;
      uart_enable = 1'b1;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      #1;
      test_reset();
      test_flags_one();
      test_flags_two();
      test_flags_zero();
      test_misc();
      end_sim();
   end
endmodule : interrupt_status_flag_bank_test

/* isfb_cpu_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// cpu side of the register port
// ----------------------------------------------------------------
module isfb_cpu_model (
   input  wire logic       core_clk,
   input  wire logic [7:0] rdata,
   output logic      [7:0] addr,
   output logic      [7:0] wdata,
   output logic            wr,
   output logic            rd
);
   initial begin
      addr  = 8'h00;
      wdata = 8'h00;
      wr    = 1'b0;
      rd    = 1'b0;
   end

   task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge core_clk);
      wr    <= 1'b0;
      // stale data is inverted so nothing can rely on it
      wdata <= ~d;
   endtask : bus_write

   // read data stand only in the cycle after the strobe
   task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge core_clk);
      rd   <= 1'b0;
      #1 d = rdata;
   endtask : bus_read
endmodule : isfb_cpu_model

/* isfb_edge_detect.sv */
`timescale 1ns/1ps
module isfb_edge_detect
   import isfb_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic rst_b,
   input  wire logic pin,
   output logic      rise,
   output logic      fall
);

   logic prev;
   logic armed;

   // ----------------------------------------------------------------
   // edge capture
   // ----------------------------------------------------------------
   // armed keeps a pin that is already high at reset release from
   // looking like a rising edge
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev  <= 1'b0;
         armed <= 1'b0;
         rise  <= 1'b0;
         fall  <= 1'b0;
      end else begin
         prev  <= pin;
         armed <= 1'b1;
         rise  <= armed & pin & ~prev;
         fall  <= armed & ~pin & prev;
      end
   end

endmodule : isfb_edge_detect

/* isfb_flag_bank.sv */
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module isfb_flag_bank
   import isfb_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [7:0]  rdata,
   input  wire isfb_events_t evt,
   input  wire logic        ext3_pin,
   input  wire logic        ext0_enable,
   input  wire logic        uart_enable,
   output isfb_flags_t      flags,
   output logic      [7:0]  irq_mask_one,
   output logic      [7:0]  irq_mask_two
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // hardware set beats a software clear arriving in the same cycle
   function automatic logic [7:0] isfb_update(
      input logic [7:0] cur,
      input logic [7:0] set,
      input logic [7:0] clr,
      input logic [7:0] valid
   );
      isfb_update = ((cur & ~clr) | set) & valid;
   endfunction : isfb_update

   // a write clears every bit written as zero, never sets one
   function automatic logic [7:0] isfb_wclr(
      input logic       hit,
      input logic [7:0] data
   );
      isfb_wclr = hit ? ~data : 8'h00;
   endfunction : isfb_wclr

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic [7:0] irq_flags_zero_edge;
   logic [7:0] irq_flags_one;
   logic [7:0] irq_flags_two;
   logic       ext3_rise;
   logic       ext3_fall;

   wire hit_zero = (addr == ISFB_ADDR_FLAGS_ZERO);
   wire hit_one  = (addr == ISFB_ADDR_FLAGS_ONE);
   wire hit_two  = (addr == ISFB_ADDR_FLAGS_TWO);
   wire hit_m1   = (addr == ISFB_ADDR_MASK_ONE);
   wire hit_m2   = (addr == ISFB_ADDR_MASK_TWO);

   wire wr_zero  = wr & hit_zero;
   wire wr_one   = wr & hit_one;
   wire wr_two   = wr & hit_two;
   wire wr_m1    = wr & hit_m1;
   wire wr_m2    = wr & hit_m2;

   // ----------------------------------------------------------------
   // ext3 edge detection
   // ----------------------------------------------------------------
   isfb_edge_detect u_ext3_edge (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .pin      (ext3_pin),
      .rise     (ext3_rise),
      .fall     (ext3_fall)
   );

   // ----------------------------------------------------------------
   // set vectors
   // ----------------------------------------------------------------
   logic [7:0] set_zero;
   logic [7:0] set_one;
   logic [7:0] set_two;

   always_comb begin
      set_zero = 8'h00;
      set_zero[ISFB_B0_EXT3_FALL] = ext3_fall;
      set_zero[ISFB_B0_EXT3_RISE] = ext3_rise;
      set_zero[ISFB_B0_WDT]       = evt.wdt_timeout;
      set_zero[ISFB_B0_EXT0]      = evt.ext0_req & ext0_enable;
   end

   always_comb begin
      set_one = 8'h00;
      set_one[ISFB_B1_EXT5]    = evt.ext5_req;
      set_one[ISFB_B1_TIMER16] = evt.timer16_irq;
      set_one[ISFB_B1_ADC]     = evt.adc_done;
      set_one[ISFB_B1_EXT3]    = evt.ext3_req;
      set_one[ISFB_B1_TIMER8B] = evt.timer8b_irq;
      set_one[ISFB_B1_SERIAL]  = evt.spi_irq;
      set_one[ISFB_B1_TIMER8A] = evt.timer8a_irq;
   end

   always_comb begin
      set_two = 8'h00;
      set_two[ISFB_B2_RX_ERR]   = evt.rx_error & uart_enable;
      set_two[ISFB_B2_RX_FULL]  = evt.rx_full;
      set_two[ISFB_B2_TX_EMPTY] = evt.tx_empty;
      set_two[ISFB_B2_TIMEBASE] = evt.timebase_tick;
      set_two[ISFB_B2_EXT1]     = evt.ext1_req;
      set_two[ISFB_B2_TICK_OVF] = evt.tick_overflow;
   end

   // ----------------------------------------------------------------
   // clear vectors
   // ----------------------------------------------------------------
   // disabling ext0 or the uart holds its flag clear; that clear is a
   // level and the matching set is gated off, so the clear always wins
   logic [7:0] clr_zero;
   logic [7:0] clr_two;
   wire  [7:0] clr_one = isfb_wclr(wr_one, wdata);

   always_comb begin
      clr_zero = isfb_wclr(wr_zero, wdata);
      clr_zero[ISFB_B0_EXT0] = clr_zero[ISFB_B0_EXT0] | ~ext0_enable;
   end

   always_comb begin
      clr_two = isfb_wclr(wr_two, wdata);
      clr_two[ISFB_B2_RX_ERR] = clr_two[ISFB_B2_RX_ERR] | ~uart_enable;
   end

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   wire [7:0] next_zero = isfb_update(irq_flags_zero_edge, set_zero, clr_zero,
                                      ISFB_VALID_ZERO);
   wire [7:0] next_one  = isfb_update(irq_flags_one, set_one, clr_one,
                                      ISFB_VALID_ONE);
   wire [7:0] next_two  = isfb_update(irq_flags_two, set_two, clr_two,
                                      ISFB_VALID_TWO);

   // read answer, masked views of registers one and two
   wire [7:0] view_one = irq_flags_one & irq_mask_one;
   wire [7:0] view_two = irq_flags_two & irq_mask_two;

   logic [7:0] next_rdata;
   always_comb begin
      next_rdata = ISFB_RDATA_IDLE;
      if (rd) begin
         unique case (1'b1)
            hit_zero: next_rdata = irq_flags_zero_edge;
            hit_one:  next_rdata = view_one;
            hit_two:  next_rdata = view_two;
            hit_m1:   next_rdata = irq_mask_one;
            hit_m2:   next_rdata = irq_mask_two;
            default:  next_rdata = ISFB_RDATA_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_flags_zero_edge <= ISFB_FLAGS_RESET;
         irq_flags_one       <= ISFB_FLAGS_RESET;
         irq_flags_two       <= ISFB_FLAGS_RESET;
      end else begin
         irq_flags_zero_edge <= next_zero;
         irq_flags_one       <= next_one;
         irq_flags_two       <= next_two;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_mask_one <= ISFB_MASK_RESET;
         irq_mask_two <= ISFB_MASK_RESET;
      end else begin
         if (wr_m1)
            irq_mask_one <= wdata;
         if (wr_m2)
            irq_mask_two <= wdata;
      end
   end

   // read data stand for one cycle only, zero otherwise
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)
         rdata <= ISFB_RDATA_IDLE;
      else
         rdata <= next_rdata;
   end

   assign flags = '{zero_edge: irq_flags_zero_edge, one: irq_flags_one, two: irq_flags_two};

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   a_ext3_fall_flag: assert property (
      ext3_fall |=> irq_flags_zero_edge[ISFB_B0_EXT3_FALL])
      else $error("ext3 falling edge flag not set");

   a_ext3_rise_flag: assert property (
      $rose(ext3_pin) ##1 1'b1 |=> ##[0:1] irq_flags_zero_edge[ISFB_B0_EXT3_RISE])
      else $error("ext3 rising edge flag not set in time");

   a_wdt_flag_sticky: assert property (
      irq_flags_zero_edge[ISFB_B0_WDT] && !(wr_zero && !wdata[ISFB_B0_WDT])
      |=> irq_flags_zero_edge[ISFB_B0_WDT])
      else $error("watchdog flag dropped without a clear");

   a_wdt_flag_set: assert property (
      evt.wdt_timeout |=> irq_flags_zero_edge[ISFB_B0_WDT])
      else $error("watchdog time-out not latched");

   a_ext0_enable_clr: assert property (
      !ext0_enable [*2] |-> !irq_flags_zero_edge[ISFB_B0_EXT0])
      else $error("ext0 flag set while ext0 disabled");

   a_set_beats_clear: assert property (
      evt.ext5_req && wr_one && !wdata[ISFB_B1_EXT5]
      |=> irq_flags_one[ISFB_B1_EXT5])
      else $error("ext5 event lost to a same-cycle clear");

   a_one_write_no_set: assert property (
      wr_one && set_one == 8'h00
      |=> irq_flags_one == ($past(irq_flags_one) & $past(wdata)))
      else $error("write to flag register one did not act as clear only");

   a_two_write_no_set: assert property (
      wr_two && set_two == 8'h00 && uart_enable
      |=> irq_flags_two == ($past(irq_flags_two) & $past(wdata)))
      else $error("write to flag register two did not act as clear only");

   a_read_masked_one: assert property (
      rd && hit_one |=> rdata == ($past(irq_flags_one) & $past(irq_mask_one)))
      else $error("register one read not masked");

   a_read_masked_two: assert property (
      rd && hit_two |=> rdata == ($past(irq_flags_two) & $past(irq_mask_two)))
      else $error("register two read not masked");

   a_uart_off_clr: assert property (
      !uart_enable |=> !irq_flags_two[ISFB_B2_RX_ERR])
      else $error("receive error flag held while uart disabled");

   a_unused_bits_zero: assert property (
      (irq_flags_zero_edge & ~ISFB_VALID_ZERO) == 8'h00 &&
      (irq_flags_one & ~ISFB_VALID_ONE) == 8'h00 &&
      (irq_flags_two & ~ISFB_VALID_TWO) == 8'h00)
      else $error("unused flag bit is set");

   a_rdata_idle_zero: assert property (
      !rd |=> rdata == ISFB_RDATA_IDLE)
      else $error("read data not zero outside a read answer");

   // ----------------------------------------------------------------
   // event latching
   // ----------------------------------------------------------------
   // every event shows in its flag one edge later (ext0 request and receive error only while enabled), whatever software
   // writes in that same cycle

   a_ext0_req_set: assert property (
      evt.ext0_req && ext0_enable |=> irq_flags_zero_edge[ISFB_B0_EXT0])
      else $error("ext0 request not latched");

   a_ext5_req_set: assert property (
      evt.ext5_req |=> irq_flags_one[ISFB_B1_EXT5])
      else $error("ext5 request not latched");

   a_timer16_set: assert property (
      evt.timer16_irq |=> irq_flags_one[ISFB_B1_TIMER16])
      else $error("16-bit timer event not latched");

   a_adc_done_set: assert property (
      evt.adc_done |=> irq_flags_one[ISFB_B1_ADC])
      else $error("conversion done event not latched");

   a_ext3_req_set: assert property (
      evt.ext3_req |=> irq_flags_one[ISFB_B1_EXT3])
      else $error("ext3 request not latched");

   a_timer8b_set: assert property (
      evt.timer8b_irq |=> irq_flags_one[ISFB_B1_TIMER8B])
      else $error("8-bit timer b event not latched");

   a_serial_set: assert property (
      evt.spi_irq |=> irq_flags_one[ISFB_B1_SERIAL])
      else $error("serial peripheral event not latched");

   a_timer8a_set: assert property (
      evt.timer8a_irq |=> irq_flags_one[ISFB_B1_TIMER8A])
      else $error("8-bit timer a event not latched");

   a_rx_error_set: assert property (
      evt.rx_error && uart_enable |=> irq_flags_two[ISFB_B2_RX_ERR])
      else $error("receive error not latched");

   a_rx_full_set: assert property (
      evt.rx_full |=> irq_flags_two[ISFB_B2_RX_FULL])
      else $error("receive buffer full not latched");

   a_tx_empty_set: assert property (
      evt.tx_empty |=> irq_flags_two[ISFB_B2_TX_EMPTY])
      else $error("transmit buffer empty not latched");

   a_timebase_set: assert property (
      evt.timebase_tick |=> irq_flags_two[ISFB_B2_TIMEBASE])
      else $error("time base event not latched");

   a_ext1_req_set: assert property (
      evt.ext1_req |=> irq_flags_two[ISFB_B2_EXT1])
      else $error("ext1 request not latched");

   a_tick_ovf_set: assert property (
      evt.tick_overflow |=> irq_flags_two[ISFB_B2_TICK_OVF])
      else $error("tick counter overflow not latched");

   a_one_flags_hold: assert property (
      !wr_one |=> (irq_flags_one & $past(irq_flags_one)) == $past(irq_flags_one))
      else $error("register one flag dropped without a write");

   a_two_flags_hold: assert property (
      !wr_two && uart_enable
      |=> (irq_flags_two & $past(irq_flags_two)) == $past(irq_flags_two))
      else $error("register two flag dropped without a write");

   a_zero_write_clr: assert property (
      wr_zero && set_zero == 8'h00 && ext0_enable
      |=> irq_flags_zero_edge == ($past(irq_flags_zero_edge) & $past(wdata)))
      else $error("write to flag register zero did not act as clear only");

   a_mask_one_write: assert property (
      wr_m1 |=> irq_mask_one == $past(wdata))
      else $error("mask one write not stored");

   a_mask_two_write: assert property (
      wr_m2 |=> irq_mask_two == $past(wdata))
      else $error("mask two write not stored");

   c_set_and_clear: cover property (
      evt.tick_overflow ##1 wr_two && !wdata[ISFB_B2_TICK_OVF]);
   c_masked_read: cover property (
      irq_flags_one != 8'h00 && irq_mask_one != 8'h00 && rd && hit_one);
   c_both_ext3_edges: cover property (
      ext3_rise ##[1:20] ext3_fall);
   c_ext0_disable: cover property (
      irq_flags_zero_edge[ISFB_B0_EXT0] ##1 !ext0_enable);

endmodule : isfb_flag_bank

/* isfb_pkg.sv */
// Function
// - ext3 falling edge sets bit 5, register zero
// - ext3 rising edge sets bit 4, register zero
// - watchdog time-out sets sticky bit 1
// - ext0 request sets bit 0; enable low clears
// - ext5 request sets bit 7, register one
// - 16-bit timer sets bit 6, register one
// - conversion done sets bit 5, register one
// - ext3 request sets bit 3, register one
// - 8-bit timer b sets bit 2
// - serial peripheral sets bit 1, register one
// - 8-bit timer a sets bit 0
// - one means pending, zero means none
// - writes to register one only clear
// - register one reads ANDed with mask one
// - receive error bit 6; uart disable clears
// - receive buffer full sets bit 5
// - transmit buffer empty sets bit 4
// - time base event sets bit 3
// - ext1 request sets bit 2, register two
// - tick counter overflow sets bit 0
// - writes to register two only clear
// - register two reads ANDed with mask two
package isfb_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ISFB_ADDR_FLAGS_ZERO = 8'h0D;
   localparam logic [7:0] ISFB_ADDR_FLAGS_ONE  = 8'h0E;
   localparam logic [7:0] ISFB_ADDR_FLAGS_TWO  = 8'h0F;
   localparam logic [7:0] ISFB_ADDR_MASK_ONE   = 8'h10;
   localparam logic [7:0] ISFB_ADDR_MASK_TWO   = 8'h11;

   localparam logic [7:0] ISFB_FLAGS_RESET     = 8'h00;
   localparam logic [7:0] ISFB_MASK_RESET      = 8'h00;
   localparam logic [7:0] ISFB_RDATA_IDLE      = 8'h00;

   // implemented bits of each flag register
   localparam logic [7:0] ISFB_VALID_ZERO      = 8'h33;
   localparam logic [7:0] ISFB_VALID_ONE       = 8'hEF;
   localparam logic [7:0] ISFB_VALID_TWO       = 8'h7D;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int ISFB_B0_EXT3_FALL = 5;
   localparam int ISFB_B0_EXT3_RISE = 4;
   localparam int ISFB_B0_WDT       = 1;
   localparam int ISFB_B0_EXT0      = 0;
   localparam int ISFB_B1_EXT5      = 7;
   localparam int ISFB_B1_TIMER16   = 6;
   localparam int ISFB_B1_ADC       = 5;
   localparam int ISFB_B1_EXT3      = 3;
   localparam int ISFB_B1_TIMER8B   = 2;
   localparam int ISFB_B1_SERIAL    = 1;
   localparam int ISFB_B1_TIMER8A   = 0;
   localparam int ISFB_B2_RX_ERR    = 6;
   localparam int ISFB_B2_RX_FULL   = 5;
   localparam int ISFB_B2_TX_EMPTY  = 4;
   localparam int ISFB_B2_TIMEBASE  = 3;
   localparam int ISFB_B2_EXT1      = 2;
   localparam int ISFB_B2_TICK_OVF  = 0;

   // one-cycle event pulses from the peripherals
   typedef struct packed {
      logic wdt_timeout;
      logic ext0_req;
      logic ext5_req;
      logic timer16_irq;
      logic adc_done;
      logic ext3_req;
      logic timer8b_irq;
      logic spi_irq;
      logic timer8a_irq;
      logic rx_error;
      logic rx_full;
      logic tx_empty;
      logic timebase_tick;
      logic ext1_req;
      logic tick_overflow;
   } isfb_events_t;

   // stored flag registers, raw (unmasked)
   typedef struct packed {
      logic [7:0] zero_edge;
      logic [7:0] one;
      logic [7:0] two;
   } isfb_flags_t;

endpackage : isfb_pkg
